/* verilog/stepper_chopper_config.sv */
// Chopper configuration register and chopper phase sequencer.
`timescale 1ns/1ps
module stepper_chopper_config
	import chopper_pkg::*;
(
	input  wire logic              i_core_clk,
	input  wire logic              i_reset_n,
	input  wire logic              i_word_valid,
	input  wire logic [WORD_W-1:0] i_word,
	input  wire logic              i_comparator_trip,
	input  wire logic              i_negative_reached,
	output logic                   o_drvctrl_write,
	output logic      [WORD_W-1:0] o_drvctrl_word,
	output logic                   o_bridge_enable,
	output logic                   o_phase_on,
	output logic                   o_phase_fast,
	output logic                   o_phase_slow,
	output logic                   o_blanking,
	output logic                   o_chopper_mode,
	output logic signed      [5:0] o_hysteresis,
	output logic             [3:0] o_sine_offset
);

	logic [WORD_W-1:0] chopper_configuration_q;
	logic              drvctrl_write_q;
	logic [WORD_W-1:0] drvctrl_word_q;
	chop_state_e       state_q;
	chop_state_e       state_d;
	logic [9:0]        timer_q;
	logic [9:0]        timer_d;
	logic signed [5:0] hyst_q;
	logic [6:0]        dec_cnt_q;

	// Address decode of incoming words.
	logic chopper_write;
	logic drvctrl_write;
	assign chopper_write = i_word_valid & i_word[SEL_BIT]
		& (i_word[TARGET_HI:TARGET_LO] == TARGET_CHOPPER);
	assign drvctrl_write = i_word_valid & ~i_word[SEL_BIT];

	// Field extraction.
	logic [1:0] blank_code;
	logic       chopper_mode_bit;
	logic       random_off_time;
	logic [1:0] hysteresis_decrement;
	logic [3:0] hysteresis_end;
	logic [2:0] hysteresis_start;
	logic [3:0] off_time;
	assign blank_code = chopper_configuration_q[BLANK_HI:BLANK_LO];
	assign chopper_mode_bit = chopper_configuration_q[MODE_BIT];
	assign random_off_time = chopper_configuration_q[RANDOM_BIT];
	assign hysteresis_decrement = chopper_configuration_q[DEC_HI:DEC_LO];
	assign hysteresis_end = chopper_configuration_q[END_HI:END_LO];
	assign hysteresis_start = chopper_configuration_q[START_HI:START_LO];
	assign off_time = chopper_configuration_q[OFF_HI:OFF_LO];

	logic driver_on;
	assign driver_on = (off_time != 4'h0);

	logic [9:0] blank_len;
	assign blank_len = BLANK_CYCLES[blank_code];

	logic [3:0] fast_setting;
	assign fast_setting = {hysteresis_decrement[0], hysteresis_start};
	logic [9:0] fast_len;
	assign fast_len = {1'b0, fast_setting, 5'h00};

	logic [9:0] off_raw;
	logic [9:0] off_nom;
	assign off_raw = OFF_BASE + {1'b0, off_time, 5'h00};
	assign off_nom = (off_raw < OFF_MIN) ? OFF_MIN : off_raw;

	logic [3:0] rand_off;
	logic [9:0] off_len;
	logic       rand_step;
	assign off_len = random_off_time
		? off_nom - RANDOM_BIAS + {6'h00, rand_off}
		: off_nom;

	random_offset random_offset_inst (
		.i_core_clk (i_core_clk),
		.i_reset_n  (i_reset_n),
		.i_step     (rand_step),
		.o_offset   (rand_off)
	);

	// Comparator is only honoured once the blank timer has run out.
	logic on_done;
	logic use_fast;
	logic fast_early;
	assign on_done = (state_q == ST_ON) && (timer_q == 10'h000)
		&& i_comparator_trip;
	assign use_fast = chopper_mode_bit && (fast_setting != 4'h0);
	assign fast_early = i_negative_reached & ~hysteresis_decrement[1];
	// A fresh off duration is drawn each time the slow phase is entered.
	assign rand_step = (state_q != state_d) && (state_d == ST_SLOW);

	always_comb begin
		state_d = state_q;
		timer_d = (timer_q != 10'h000) ? timer_q - 10'h001 : timer_q;
		unique case (state_q)
			ST_DISABLED: begin
				if (driver_on) begin
					state_d = ST_ON;
					timer_d = blank_len;
				end
			end
			ST_ON: begin
				if (on_done && use_fast) begin
					state_d = ST_FAST;
					timer_d = fast_len;
				end else if (on_done) begin
					state_d = ST_SLOW;
					timer_d = off_len;
				end
			end
			ST_FAST: begin
				if (timer_q <= 10'h001 || fast_early) begin
					state_d = ST_SLOW;
					timer_d = off_len;
				end
			end
			ST_SLOW: begin
				if (timer_q <= 10'h001) begin
					state_d = ST_ON;
					timer_d = blank_len;
				end
			end
		endcase
		if (!driver_on) begin
			state_d = ST_DISABLED;
			timer_d = 10'h000;
		end
	end

	logic signed [5:0] hyst_low;
	logic signed [5:0] hyst_start;
	assign hyst_low = $signed({2'b00, hysteresis_end})
		- $signed(HYST_END_BIAS);
	assign hyst_start = hyst_low + $signed({3'b000, hysteresis_start})
		+ $signed(HYST_START_BIAS);

	// decrement period 16 per code step
	logic [6:0] dec_period;
	logic       dec_tick;
	assign dec_period = {hysteresis_decrement + 2'h1 == 2'h0 ? 3'h4
		: {1'b0, hysteresis_decrement + 2'h1}, 4'h0};
	assign dec_tick = (dec_cnt_q >= dec_period - 7'h01);

	always_ff @(posedge i_core_clk) begin
		if (!i_reset_n) begin
			chopper_configuration_q <= CHOPPER_CONFIG_RESET;
			drvctrl_write_q <= 1'b0;
			drvctrl_word_q <= '0;
		end else begin
			if (chopper_write) begin
				chopper_configuration_q <= i_word;
			end
			drvctrl_write_q <= drvctrl_write;
			if (drvctrl_write) begin
				drvctrl_word_q <= i_word;
			end
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_reset_n) begin
			state_q <= ST_DISABLED;
			timer_q <= 10'h000;
		end else begin
			state_q <= state_d;
			timer_q <= timer_d;
		end
	end

	// Hysteresis restarts high at each on phase and sinks toward the low.
	always_ff @(posedge i_core_clk) begin
		if (!i_reset_n) begin
			hyst_q <= 6'sh00;
			dec_cnt_q <= 7'h00;
		end else if (state_q != ST_ON && state_d == ST_ON) begin
			hyst_q <= hyst_start;
			dec_cnt_q <= 7'h00;
		end else if (dec_tick) begin
			dec_cnt_q <= 7'h00;
			if (hyst_q > hyst_low) begin
				hyst_q <= hyst_q - 6'sh01;
			end
		end else begin
			dec_cnt_q <= dec_cnt_q + 7'h01;
		end
	end

	assign o_drvctrl_write = drvctrl_write_q;
	assign o_drvctrl_word  = drvctrl_word_q;
	assign o_bridge_enable = (state_q != ST_DISABLED);
	assign o_phase_on      = (state_q == ST_ON);
	assign o_phase_fast    = (state_q == ST_FAST);
	assign o_phase_slow    = (state_q == ST_SLOW);
	assign o_blanking      = (state_q == ST_ON) && (timer_q != 10'h000);
	assign o_chopper_mode  = chopper_mode_bit;
	assign o_hysteresis    = chopper_mode_bit ? 6'sh00 : hyst_q;
	assign o_sine_offset   = chopper_mode_bit ? hysteresis_end : 4'h0;

endmodule

/* verilog/chopper_pkg.sv */
// Shared constants and types for the chopper configuration block.
package chopper_pkg;

	// Configuration word layout.
	localparam int unsigned WORD_W    = 20;
	localparam int unsigned SEL_BIT   = 19;
	localparam int unsigned TARGET_HI = 18;
	localparam int unsigned TARGET_LO = 17;
	localparam int unsigned BLANK_HI  = 16;
	localparam int unsigned BLANK_LO  = 15;
	localparam int unsigned MODE_BIT  = 14;
	localparam int unsigned RANDOM_BIT = 13;
	localparam int unsigned DEC_HI    = 12;
	localparam int unsigned DEC_LO    = 11;
	localparam int unsigned END_HI    = 10;
	localparam int unsigned END_LO    = 7;
	localparam int unsigned START_HI  = 6;
	localparam int unsigned START_LO  = 4;
	localparam int unsigned OFF_HI    = 3;
	localparam int unsigned OFF_LO    = 0;

	localparam logic [1:0]  TARGET_CHOPPER = 2'h0;
	localparam logic [19:0] CHOPPER_CONFIG_RESET = 20'h00000;

	// Timing in system clock cycles, hysteresis biases and the random seed.
	localparam logic [9:0] BLANK_CYCLES [4] = '{10'h010, 10'h018,
		10'h024, 10'h036};
	localparam logic [9:0] OFF_BASE     = 10'h00C;
	localparam logic [9:0] OFF_MIN      = 10'h040;
	localparam logic [9:0] RANDOM_BIAS  = 10'h00C;
	localparam logic [5:0] HYST_END_BIAS = 6'h03;
	localparam logic [5:0] HYST_START_BIAS = 6'h01;
	localparam logic [4:0] LFSR_SEED    = 5'h01;

	typedef enum logic [1:0] {
		ST_DISABLED,
		ST_ON,
		ST_FAST,
		ST_SLOW
	} chop_state_e;

endpackage

/* verilog/random_offset.sv */
// Pseudo random source for off-time modulation.
`timescale 1ns/1ps
module random_offset
	import chopper_pkg::*;
(
	input  wire logic       i_core_clk,
	input  wire logic       i_reset_n,
	input  wire logic       i_step,
	output logic      [3:0] o_offset
);

	logic [4:0] lfsr_q;
	logic [4:0] lfsr_d;

	// Maximal length five bit sequence; the low nibble covers all 16 codes.
	assign lfsr_d   = {lfsr_q[3:0], lfsr_q[4] ^ lfsr_q[2]};
	assign o_offset = lfsr_q[3:0];

	always_ff @(posedge i_core_clk) begin
		if (!i_reset_n) begin
			lfsr_q <= LFSR_SEED;
		end else if (i_step) begin
			lfsr_q <= lfsr_d;
		end
	end

endmodule

/* verification/host_model.sv */
// Host side that writes whole configuration words.
`timescale 1ns/1ps
module host_model (
	input  wire logic        i_core_clk,
	output logic             o_word_valid,
	output logic      [19:0] o_word
);
	initial begin
		o_word_valid = 1'b0;
		o_word = 20'h0;
	end
	task automatic send(input logic [19:0] w);
		@(posedge i_core_clk);
		o_word_valid <= 1'b1;
		o_word <= w;
		@(posedge i_core_clk);
		o_word_valid <= 1'b0;
		// A released word must not look valid, so it is inverted.
		o_word <= ~w;
	endtask
endmodule

/* verification/chop_monitor.sv */
// Port checker for the chopper block.
`timescale 1ns/1ps
module chop_monitor (
	input wire logic               i_core_clk,
	input wire logic               i_reset_n,
	input wire logic               i_word_valid,
	input wire logic        [19:0] i_word,
	input wire logic               o_drvctrl_write,
	input wire logic        [19:0] o_drvctrl_word,
	input wire logic               o_bridge_enable,
	input wire logic               o_phase_on,
	input wire logic               o_phase_fast,
	input wire logic               o_phase_slow,
	input wire logic               o_blanking,
	input wire logic               o_chopper_mode,
	input wire logic signed  [5:0] o_hysteresis,
	input wire logic         [3:0] o_sine_offset
);
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_reset_n);
	logic [19:0] w_q;
	wire chop = i_word_valid && i_word[19:17] == 3'h4;
	wire drv = i_word_valid && !i_word[19];
	logic [19:0] cfg_q;
	always_ff @(posedge i_core_clk) w_q <= i_word;
	// Shadow of the last accepted chopper word, for hysteresis checks.
	always_ff @(posedge i_core_clk) begin
		if (chop) begin
			cfg_q <= i_word;
		end
	end
	sequence s_chop;
		chop ##1 1'b1;
	endsequence
	property p_drv;
		drv |=> o_drvctrl_write && o_drvctrl_word == w_q;
	endproperty
	a_drv: assert property (p_drv) else $error("drv copy");
	property p_nodrv;
		!drv |=> !o_drvctrl_write;
	endproperty
	a_nodrv: assert property (p_nodrv) else $error("drv pulse");
	property p_off;
		chop && i_word[3:0] == 4'h0 |-> ##2 !o_bridge_enable;
	endproperty
	a_off: assert property (p_off) else $error("not off");
	property p_on;
		chop && i_word[3:0] != 4'h0 |-> ##2 o_bridge_enable;
	endproperty
	a_on: assert property (p_on) else $error("not on");
	property p_one;
		o_bridge_enable == (o_phase_on | o_phase_fast | o_phase_slow)
			&& $onehot0({o_phase_on, o_phase_fast, o_phase_slow});
	endproperty
	a_one: assert property (p_one) else $error("phase");
	property p_mode;
		s_chop |-> o_chopper_mode == w_q[14]
			&& o_sine_offset == (w_q[14] ? w_q[10:7] : 4'h0);
	endproperty
	a_mode: assert property (p_mode) else $error("cfg");
	property p_ref;
		i_word_valid && i_word[19] && i_word[18:17] != 2'h0
			|=> $stable(o_chopper_mode) && $stable(o_sine_offset);
	endproperty
	a_ref: assert property (p_ref) else $error("refused");
	property p_blank;
		($rose(o_phase_on) |-> o_blanking) and (o_blanking |-> o_phase_on);
	endproperty
	a_blank: assert property (p_blank) else $error("blank");
	property p_hys;
		o_chopper_mode [*2] |-> o_hysteresis == 6'sh00;
	endproperty
	a_hys: assert property (p_hys) else $error("hyst");
	property p_hys_start;
		!o_chopper_mode && !$past(cfg_q[14]) && $rose(o_phase_on)
			|-> o_hysteresis == $signed(6'({2'b00, $past(cfg_q[10:7])}
			+ {3'b000, $past(cfg_q[6:4])} - 6'h02));
	endproperty
	a_hys_start: assert property (p_hys_start) else $error("hstart");
endmodule

bind stepper_chopper_config chop_monitor chop_monitor_inst (
	.i_core_clk(i_core_clk), .i_reset_n(i_reset_n),
	.i_word_valid(i_word_valid), .i_word(i_word),
	.o_drvctrl_write(o_drvctrl_write), .o_drvctrl_word(o_drvctrl_word),
	.o_bridge_enable(o_bridge_enable), .o_phase_on(o_phase_on),
	.o_phase_fast(o_phase_fast), .o_phase_slow(o_phase_slow),
	.o_blanking(o_blanking), .o_chopper_mode(o_chopper_mode),
	.o_hysteresis(o_hysteresis), .o_sine_offset(o_sine_offset));

/* verification/stepper_chopper_config_bench.sv */
// Self-checking bench for the chopper configuration block.
`timescale 1ns/1ps
module stepper_chopper_config_bench;
	import chopper_pkg::*;
	logic i_core_clk, i_reset_n, i_word_valid, trip, neg;
	logic drv_wr, bridge, on, fast, slow, blank, mode;
	logic [19:0] i_word, drv_word;
	logic signed [5:0] hyst;
	logic [3:0] sine;
	int err_count = 0;
	int total_checks = 0;
	int n, k;
	int lens [4] = '{16, 24, 36, 54};
	int offs [3] = '{64, 76, 492};
	logic [3:0] toffs [3] = '{4'h1, 4'h2, 4'hF};

	stepper_chopper_config stepper_chopper_config_inst (
		.i_core_clk(i_core_clk), .i_reset_n(i_reset_n),
		.i_word_valid(i_word_valid), .i_word(i_word),
		.i_comparator_trip(trip), .i_negative_reached(neg),
		.o_drvctrl_write(drv_wr), .o_drvctrl_word(drv_word),
		.o_bridge_enable(bridge), .o_phase_on(on), .o_phase_fast(fast),
		.o_phase_slow(slow), .o_blanking(blank), .o_chopper_mode(mode),
		.o_hysteresis(hyst), .o_sine_offset(sine));
	host_model host_model_inst (.i_core_clk(i_core_clk),
		.o_word_valid(i_word_valid), .o_word(i_word));

	initial begin
		i_core_clk = 1'b0;
		forever #2.5 i_core_clk = ~i_core_clk;
	end

	task automatic end_of_test();
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	task automatic chk(input string s, input logic [19:0] e, g);
		total_checks++;
		if (g !== e) begin
			err_count++;
			$display("CHECK FAILED %s exp %h got %h", s, e, g);
		end
	endtask

	function automatic logic ph(input int s);
		return s == 0 ? blank : s == 1 ? slow : fast;
	endfunction

	// Counts the cycles a phase stays high, sampled off the active edge.
	task automatic dur(input int s);
		n = 0;
		k = 0;
		@(negedge i_core_clk);
		while (!ph(s) && k < 600) begin
			@(negedge i_core_clk);
			k++;
		end
		while (ph(s) && n < 600) begin
			@(negedge i_core_clk);
			n++;
		end
		if (k == 600 || n == 600) begin
			err_count++;
			end_of_test();
		end
	endtask

	function automatic logic [19:0] cw(input logic [1:0] t, m, d,
		input logic [3:0] h, input logic [2:0] s, input logic [3:0] f);
		return {3'h4, t, m, d, h, s, f};
	endfunction

	// Disabling first forces a fresh on phase for each measurement.
	task automatic go(input logic [19:0] w);
		host_model_inst.send({w[19:4], 4'h0});
		host_model_inst.send(w);
	endtask

	initial begin
		i_reset_n = 1'b0;
		trip = 1'b1;
		neg = 1'b1;
		repeat (2) @(posedge i_core_clk);
		i_reset_n <= 1'b1;
		@(negedge i_core_clk);
		chk("bridge", 20'h0, 20'(bridge));
		host_model_inst.send(20'h0ABCD);
		@(negedge i_core_clk);
		chk("drv_wr", 20'h1, 20'(drv_wr));
		chk("drv_word", 20'h0ABCD, drv_word);
		for (int c = 0; c < 4; c++) begin
			go(cw(2'(c), 2'h0, 2'h3, 4'h5, 3'h7, 4'h2));
			dur(0);
			chk("blank", 20'(lens[c]), 20'(n));
			chk("hyst", 20'hA, 20'(hyst));
		end
		for (int c = 0; c < 3; c++) begin
			go(cw(2'h0, 2'h0, 2'h0, 4'h3, 3'h0, toffs[c]));
			dur(1);
			chk("off", 20'(offs[c]), 20'(n));
		end
		go(cw(2'h0, 2'h1, 2'h0, 4'h3, 3'h0, 4'h4));
		dur(1);
		chk("rnd", 20'h1, 20'(n >= 128 && n <= 143));
		go(cw(2'h0, 2'h2, 2'h2, 4'h9, 3'h1, 4'h2));
		@(negedge i_core_clk);
		chk("sine", 20'h9, 20'(sine));
		dur(2);
		chk("fast", 20'h20, 20'(n));
		@(posedge i_core_clk);
		trip <= 1'b0;
		go(cw(2'h0, 2'h0, 2'h0, 4'h3, 3'h0, 4'h2));
		repeat (40) @(negedge i_core_clk);
		chk("hold", 20'h1, 20'(on));
		@(posedge i_core_clk);
		trip <= 1'b1;
		neg <= 1'b0;
		go(cw(2'h0, 2'h2, 2'h1, 4'h9, 3'h0, 4'h2));
		dur(2);
		chk("fast8", 20'h100, 20'(n));
		@(posedge i_core_clk);
		neg <= 1'b1;
		go(cw(2'h0, 2'h2, 2'h0, 4'h9, 3'h1, 4'h2));
		dur(2);
		chk("early", 20'h1, 20'(n < 32));
		host_model_inst.send(20'hA0000);
		@(negedge i_core_clk);
		chk("mode", 20'h1, 20'(mode));
		host_model_inst.send(20'h80000);
		repeat (2) @(negedge i_core_clk);
		chk("bridge", 20'h0, 20'(bridge));
		end_of_test();
	end
endmodule
